// *** shared/ref_select_holdover_monitor_regs.vh ***
// Constants for the reference select and holdover monitor
`ifndef REF_SELECT_HOLDOVER_MONITOR_REGS_VH
`define REF_SELECT_HOLDOVER_MONITOR_REGS_VH

// Ratio select codes
`define MODE_BYPASS      2'h0
`define MODE_HALF        2'h1
`define MODE_X2          2'h2
`define MODE_X6          2'h3

// Crystal edges and reference edges making one compare window, per mode
`define WIN_XTAL_HALF    2'h2
`define WIN_XTAL_OTHER   2'h1
`define WIN_REF_HALF     4'h1
`define WIN_REF_X2       4'h2
`define WIN_REF_X6       4'h6

// Allowed slip of reference edges per window before leaving capture range
`define CAPTURE_TOL      4'h1

// Failure assert and clear, in crystal periods (one period is t_ref times n)
`define FAIL_PERIODS     4'h2
`define FAIL_PERIODS_HALF 4'h3
`define CLEAR_PERIODS    4'hc

// Fixed part of both delays and the system clock period
`define MARGIN_NS        25
`define CLK_NS           50
// Least time, so rounded up to whole cycles (never below one)
`define MARGIN_CYC       (((`MARGIN_NS) + (`CLK_NS) - 1) / (`CLK_NS))

// Capacitor array code and its nominal pull span
`define PULL_RANGE_PPM   300
`define TUNE_RESET       8'h80
`define TUNE_MIN         8'h00
`define TUNE_MAX         8'hff

// Holdover generator half period before any measurement
`define HALF_PER_RESET   16'h0004

// Monitor states
`define ST_RUN           2'h0
`define ST_FAIL          2'h1
`define ST_RECOVER       2'h2
`define ST_MARGIN        2'h3

`endif

// *** verilog/edge_watch.v ***
// Rising and falling edge detector for a group of synchronous inputs
`timescale 1ns/100ps
`default_nettype none

module edge_watch #(
  parameter WIDTH = 3
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             rst,
  // Levels to watch
  input  wire [WIDTH-1:0] level_in,
  // Registered level and one-cycle edge pulses
  output reg  [WIDTH-1:0] level_r,
  output wire [WIDTH-1:0] rise,
  output wire [WIDTH-1:0] fall
);

  reg [WIDTH-1:0] prev_r;  // Level one cycle older

  // Two stages so edges are seen on registered values only
  always @(posedge clk_sys) begin
    if (rst) begin
      // Load the present level so an idle-high pin gives no edge after reset
      level_r <= level_in;
      prev_r  <= level_in;
    end else begin
      level_r <= level_in;
      prev_r  <= level_r;
    end
  end

  assign rise = level_r & ~prev_r;
  assign fall = ~level_r & prev_r;

endmodule // edge_watch

`default_nettype wire

// *** verilog/ref_select_holdover_monitor.v ***
// Reference selection, ratio mode, validity monitor and holdover loop model
`timescale 1ns/100ps
`default_nettype none
`include "ref_select_holdover_monitor_regs.vh"

// Behaviour
// - Chooser high picks primary, low picks secondary
// - Ratio code 00 bypasses loop and crystal
// - Codes 01/10/11 give ratios 1/2, 2, 6
// - Outputs run at reference rate, phase aligned
// - Validity flag high valid, low invalid
// - Lost reference freezes tuning, drops flag
// - Tune only inside capture range, else invalid
// - Back in range clears flag, resumes alignment
// - Fail within two crystal periods (three in half mode) plus 25ns
// - Clear no sooner than twelve periods plus 25ns
// - Resynchronise automatically once reference returns
// - Outputs from crystal loop, phase moves gradually
// - Capacitor array pulls crystal about 300ppm
// - Undriven ratio selects read high
// - Outputs sit low when not driven
module ref_select_holdover_monitor #(
  parameter TUNE_W = 8,
  parameter PER_W  = 16
) (
  // Clock and reset
  input  wire              clk_sys,
  input  wire              rst,
  // Reference clocks and chooser
  input  wire              primary_clock_input,
  input  wire              secondary_clock_input,
  input  wire              input_chooser,
  // Ratio straps and their undriven flags
  input  wire [1:0]        ratio_select,
  input  wire [1:0]        ratio_float,
  // Crystal clock level and feedback loop return
  input  wire              tunable_crystal_osc,
  input  wire              feedback_input,
  // Clock outputs
  output reg  [1:0]        bank_a_outputs,
  output reg  [1:0]        bank_b_outputs,
  // Status and crystal tuning
  output reg               ref_valid,
  output reg               bypass_active,
  output reg  [TUNE_W-1:0] tune_code
);

  // Crystal edges that close one compare window
  function [1:0] win_xtal;
    input [1:0] mode;
    begin
      win_xtal = (mode == `MODE_HALF) ? `WIN_XTAL_HALF : `WIN_XTAL_OTHER;
    end
  endfunction

  // Reference edges expected inside one window
  function [3:0] win_ref;
    input [1:0] mode;
    begin
      case (mode)
        `MODE_HALF: win_ref = `WIN_REF_HALF;
        `MODE_X2:   win_ref = `WIN_REF_X2;
        default:    win_ref = `WIN_REF_X6;
      endcase
    end
  endfunction

  localparam integer MARGIN_INT = `MARGIN_CYC;   // Fixed 25ns part, full width
  localparam [3:0] MARGIN_CYC = MARGIN_INT[3:0]; // Fixed 25ns part in cycles
  localparam [TUNE_W-1:0] TUNE_RESET = `TUNE_RESET;
  localparam [TUNE_W-1:0] TUNE_MAX   = `TUNE_MAX;
  localparam [TUNE_W-1:0] TUNE_MIN   = `TUNE_MIN;

  // Effective ratio code: floating straps read as one
  wire [1:0] mode = ratio_select | ratio_float;
  wire       bypass = (mode == `MODE_BYPASS);

  // Active reference, switched ahead of both the loop and the bypass output path
  wire sel_ref = input_chooser ? primary_clock_input : secondary_clock_input;

  // Edge pulses for reference, crystal and feedback
  wire [2:0] lvl;
  wire [2:0] rise;
  wire [2:0] fall;

  edge_watch #(
    .WIDTH (3)
  ) u_edges (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .level_in ({feedback_input, tunable_crystal_osc, sel_ref}),
    .level_r  (lvl),
    .rise     (rise),
    .fall     ()
  );

  wire ref_rise  = rise[0];
  wire xtal_rise = rise[1];
  wire fb_rise   = rise[2];

  // Monitor state
  reg [1:0]        state_r, state_nxt;     // Validity state
  reg [3:0]        miss_r;                 // Crystal edges since last ref edge
  reg [1:0]        xwin_r;                 // Crystal edges in open window
  reg [3:0]        rwin_r;                 // Reference edges in open window
  reg [3:0]        good_r, good_nxt;       // Clean crystal periods in recovery
  reg [3:0]        marg_r, marg_nxt;       // Fixed margin countdown
  // Holdover generator
  reg [PER_W-1:0]  per_cnt_r;              // Cycles since last ref edge
  reg [PER_W-1:0]  half_r;                 // Last good half period
  reg [PER_W-1:0]  gen_r;                  // Generator countdown
  reg              loop_clk_r;             // Regenerated loop clock
  reg              ref_pend_r;             // Ref edge seen, feedback not yet
  reg [1:0]        adj_r;                  // Pending phase step: 01 slow, 10 fast

  // Failure threshold: one extra edge in half mode, where two crystal
  // edges per reference period is the normal gap
  wire [3:0] fail_lim = (mode == `MODE_HALF) ? `FAIL_PERIODS_HALF : `FAIL_PERIODS;
  wire       missing  = (miss_r >= fail_lim);

  // Window close and capture range test
  wire [3:0] rwin_tot = rwin_r + {3'h0, ref_rise};
  wire [3:0] exp_ref  = win_ref(mode);
  wire       win_done = xtal_rise && ((xwin_r + 2'h1) == win_xtal(mode));
  wire       too_fast = (rwin_tot > exp_ref);
  wire       too_slow = (rwin_tot < exp_ref);
  wire       in_range = (rwin_tot <= exp_ref + `CAPTURE_TOL) &&
                        (rwin_tot + `CAPTURE_TOL >= exp_ref);
  wire       locked   = (state_r == `ST_RUN) && !bypass;

  // Missing reference counter on crystal edges
  always @(posedge clk_sys) begin
    if (rst) begin
      miss_r <= 4'h0;
    end else if (ref_rise || bypass) begin
      miss_r <= 4'h0;
    end else if (xtal_rise && (miss_r != 4'hf)) begin
      miss_r <= miss_r + 4'h1;
    end
  end

  // Compare window: count reference edges per crystal window
  always @(posedge clk_sys) begin
    if (rst || bypass) begin
      xwin_r <= 2'h0;
      rwin_r <= 4'h0;
    end else if (win_done) begin
      xwin_r <= 2'h0;
      rwin_r <= 4'h0;
    end else begin
      if (xtal_rise) begin
        xwin_r <= xwin_r + 2'h1;
      end
      // Saturate so a runaway reference stays out of range
      if (ref_rise && (rwin_r != 4'hf)) begin
        rwin_r <= rwin_r + 4'h1;
      end
    end
  end

  // Validity state machine
  always @* begin
    state_nxt = state_r;
    good_nxt  = good_r;
    marg_nxt  = marg_r;
    case (state_r)
      `ST_RUN: begin
        // Lost or out of range reference drops to failure
        if (!bypass && (missing || (win_done && !in_range))) begin
          state_nxt = `ST_FAIL;
        end
      end
      `ST_FAIL: begin
        // Reference back in range starts the clear delay
        if (!missing && win_done && in_range) begin
          state_nxt = `ST_RECOVER;
          good_nxt  = 4'h0;
        end
      end
      `ST_RECOVER: begin
        if (missing || (win_done && !in_range)) begin
          state_nxt = `ST_FAIL;
        end else if (xtal_rise) begin
          if (good_r + 4'h1 >= `CLEAR_PERIODS) begin
            state_nxt = `ST_MARGIN;
            marg_nxt  = MARGIN_CYC;
          end else begin
            good_nxt = good_r + 4'h1;
          end
        end
      end
      `ST_MARGIN: begin
        if (missing || (win_done && !in_range)) begin
          state_nxt = `ST_FAIL;
        end else if (marg_r <= 4'h1) begin
          state_nxt = `ST_RUN;
        end else begin
          marg_nxt = marg_r - 4'h1;
        end
      end
      default: begin
        state_nxt = `ST_FAIL;
      end
    endcase
    // Bypass leaves the monitor idle and judging nothing
    if (bypass) begin
      state_nxt = `ST_RUN;
    end
  end

  // State registers; start in failure until a reference is proven
  always @(posedge clk_sys) begin
    if (rst) begin
      state_r <= `ST_FAIL;
      good_r  <= 4'h0;
      marg_r  <= 4'h0;
    end else begin
      state_r <= state_nxt;
      good_r  <= good_nxt;
      marg_r  <= marg_nxt;
    end
  end

  // Capacitor array code: steps one per window, frozen outside lock.
  // Full code span stands for roughly +/- PULL_RANGE_PPM.
  always @(posedge clk_sys) begin
    if (rst) begin
      tune_code <= TUNE_RESET;
    end else if (locked && win_done && in_range && !missing) begin
      if (too_fast && (tune_code != TUNE_MAX)) begin
        tune_code <= tune_code + {{(TUNE_W-1){1'b0}}, 1'b1};
      end else if (too_slow && (tune_code != TUNE_MIN)) begin
        tune_code <= tune_code - {{(TUNE_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Reference period measurement, kept only while locked so that
  // holdover replays the last good rate
  always @(posedge clk_sys) begin
    if (rst) begin
      per_cnt_r <= {PER_W{1'b0}};
      half_r    <= `HALF_PER_RESET;
    end else if (ref_rise) begin
      per_cnt_r <= {PER_W{1'b0}};
      if (locked && (per_cnt_r != {PER_W{1'b0}})) begin
        half_r <= (per_cnt_r + {{(PER_W-1){1'b0}}, 1'b1}) >> 1;
      end
    end else if (per_cnt_r != {PER_W{1'b1}}) begin
      per_cnt_r <= per_cnt_r + {{(PER_W-1){1'b0}}, 1'b1};
    end
  end

  // Phase detector against the feedback return; lag speeds up the
  // generator by one cycle, lead slows it, never a jump
  always @(posedge clk_sys) begin
    if (rst) begin
      ref_pend_r <= 1'b0;
      adj_r      <= 2'h0;
    end else begin
      if (ref_rise) begin
        ref_pend_r <= 1'b1;
      end else if (fb_rise) begin
        ref_pend_r <= 1'b0;
      end
      if (!locked) begin
        adj_r <= 2'h0;
      end else if (fb_rise && !ref_rise) begin
        adj_r <= ref_pend_r ? 2'h2 : 2'h1;
      end else if (gen_r == {PER_W{1'b0}}) begin
        adj_r <= 2'h0;
      end
    end
  end

  // Loop clock generator: runs from the stored half period half_r always,
  // so losing the reference leaves its rate at the last locked value
  always @(posedge clk_sys) begin
    if (rst) begin
      gen_r      <= `HALF_PER_RESET;
      loop_clk_r <= 1'b0;
    end else if (gen_r == {PER_W{1'b0}}) begin
      loop_clk_r <= ~loop_clk_r;
      if (adj_r == 2'h2 && half_r > {{(PER_W-2){1'b0}}, 2'h2}) begin
        gen_r <= half_r - {{(PER_W-2){1'b0}}, 2'h2};
      end else if (adj_r == 2'h1) begin
        gen_r <= half_r;
      end else begin
        gen_r <= half_r - {{(PER_W-1){1'b0}}, 1'b1};
      end
    end else begin
      gen_r <= gen_r - {{(PER_W-1){1'b0}}, 1'b1};
    end
  end

  // Output banks: reference itself in bypass, loop clock otherwise.
  // Reset holds them low, as the pull-downs would.
  always @(posedge clk_sys) begin
    if (rst) begin
      bank_a_outputs <= 2'h0;
      bank_b_outputs <= 2'h0;
    end else if (bypass) begin
      bank_a_outputs <= {2{lvl[0]}};
      bank_b_outputs <= {2{lvl[0]}};
    end else begin
      bank_a_outputs <= {2{loop_clk_r}};
      bank_b_outputs <= {2{loop_clk_r}};
    end
  end

  // Status outputs
  always @(posedge clk_sys) begin
    if (rst) begin
      ref_valid     <= 1'b0;
      bypass_active <= 1'b0;
    end else begin
      ref_valid     <= (state_nxt == `ST_RUN);
      bypass_active <= bypass;
    end
  end

endmodule // ref_select_holdover_monitor

`default_nettype wire

// *** testbench/ref_select_holdover_monitor_properties.sv ***
// Port relations checker for the reference monitor, bound to the top module
`timescale 1ns/100ps
`default_nettype none
module ref_select_holdover_monitor_properties #(
  parameter TUNE_W = 8
) (
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              rst,
  // Ratio straps
  input wire logic [1:0]        ratio_select,
  input wire logic [1:0]        ratio_float,
  // Outputs watched
  input wire logic [1:0]        bank_a_outputs,
  input wire logic [1:0]        bank_b_outputs,
  input wire logic              ref_valid,
  input wire logic              bypass_active,
  input wire logic [TUNE_W-1:0] tune_code
);
  logic [15:0] low_cnt_r;                      // Cycles with the flag low
  wire  [1:0]  eff_code = ratio_select | ratio_float; // Undriven bits read high
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Saturating count of low-flag cycles
  always @(posedge clk_sys) begin
    if (rst || ref_valid) begin
      low_cnt_r <= 16'h0000;
    end else if (low_cnt_r != 16'hffff) begin
      low_cnt_r <= low_cnt_r + 16'h0001;
    end
  end
  AST_RESET_STATE: assert property ($past(rst) |-> bank_a_outputs == 2'h0 && bank_b_outputs == 2'h0
    && !ref_valid && !bypass_active && tune_code == 8'h80) else $error("state after reset wrong");
  AST_BYPASS_ON: assert property ((eff_code == 2'h0) [*4] |=> bypass_active)
    else $error("bypass not entered");
  AST_BYPASS_OFF: assert property ((eff_code != 2'h0) [*4] |=> !bypass_active)
    else $error("bypass in ratio mode");
  AST_BANKS_EQUAL: assert property (bank_a_outputs == bank_b_outputs && bank_a_outputs[0] == bank_a_outputs[1])
    else $error("outputs differ");
  AST_HOLD_TUNE: assert property (!ref_valid |=> $stable(tune_code))
    else $error("tuning moved while invalid");
  AST_TUNE_STEP: assert property ($changed(tune_code) |-> tune_code == $past(tune_code) + 1
    || tune_code == $past(tune_code) - 1) else $error("tuning jumped");
  AST_OUT_SMOOTH: assert property (!bypass_active && $changed(bank_a_outputs) ##1 !bypass_active |-> $stable(bank_a_outputs))
    else $error("output glitch");
  AST_CLEAR_LATE: assert property ($rose(ref_valid) && eff_code != 2'h0 && $past(eff_code, 4) != 2'h0
    |-> low_cnt_r >= 16'h0014) else $error("flag cleared too soon");
  cover property ($fell(ref_valid));
  cover property ($rose(ref_valid));
  cover property ($rose(bypass_active));
  cover property ($changed(tune_code));
endmodule // ref_select_holdover_monitor_properties
bind ref_select_holdover_monitor ref_select_holdover_monitor_properties #(.TUNE_W(TUNE_W)) u_props (
  .clk_sys(clk_sys), .rst(rst), .ratio_select(ratio_select), .ratio_float(ratio_float),
  .bank_a_outputs(bank_a_outputs), .bank_b_outputs(bank_b_outputs), .ref_valid(ref_valid),
  .bypass_active(bypass_active), .tune_code(tune_code));
`default_nettype wire

// *** testbench/ref_clock_source_model.sv ***
// Reference sources, crystal and board straps around the monitor
`timescale 1ns/100ps
`default_nettype none
module ref_clock_source_model (
  // Clock and pacing in system cycles
  input  wire logic       clk_sys,
  input  var  int         ref_half,
  input  var  int         xtal_half,
  // Source enables and strap drive
  input  wire logic       prim_run,
  input  wire logic       sec_run,
  input  wire logic [1:0] strap_val,
  input  wire logic [1:0] strap_drv,
  // Output returned by the board
  input  wire logic [1:0] bank_a_outputs,
  // Device inputs
  output logic            primary_clock_input,
  output logic            secondary_clock_input,
  output logic            tunable_crystal_osc,
  output logic [1:0]      ratio_select,
  output logic [1:0]      ratio_float,
  output logic            feedback_input
);
  int rc; // Reference phase counter
  int xc; // Crystal phase counter
  initial begin
    primary_clock_input = 1'b0;
    secondary_clock_input = 1'b1; // Second source half a cycle apart
    tunable_crystal_osc = 1'b0;
    rc = 0;
    xc = 0;
  end
  // Sources move just after the edge; a stopped reference stands still
  always @(posedge clk_sys) begin
    #1;
    rc = rc + 1;
    if (rc >= ref_half) begin
      rc = 0;
      if (prim_run) primary_clock_input = ~primary_clock_input;
      if (sec_run) secondary_clock_input = ~secondary_clock_input;
    end
    xc = xc + 1;
    if (xc >= xtal_half) begin
      xc = 0;
      tunable_crystal_osc = ~tunable_crystal_osc;
    end
  end
  assign ratio_select = strap_val | ~strap_drv;
  assign ratio_float = ~strap_drv;
  assign feedback_input = bank_a_outputs[0];
endmodule // ref_clock_source_model
`default_nettype wire

// *** testbench/ref_select_holdover_monitor_tb_top.sv ***
// Self-checking bench for the reference select and holdover monitor
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("BAD %0t value mismatch", $time); end end
module ref_select_holdover_monitor_tb_top;
  logic       clk_sys, rst, input_chooser, prim_run, sec_run, ok;
  logic [1:0] strap_val, strap_drv;
  logic [7:0] t0;                       // Tuning held at failure
  logic       byp_seen;                 // Model: bypass due from straps seen at this edge
  int         ref_half, xtal_half, per, m, n, seed, bad_count, cmp_count;
  wire logic  primary_clock_input, secondary_clock_input, tunable_crystal_osc, feedback_input;
  wire logic  ref_valid, bypass_active;
  wire logic [1:0] ratio_select, ratio_float, bank_a_outputs, bank_b_outputs;
  wire logic [7:0] tune_code;
  // 20 MHz system clock
  always #25 clk_sys = ~clk_sys;
  ref_clock_source_model u_src (.clk_sys(clk_sys), .ref_half(ref_half), .xtal_half(xtal_half),
    .prim_run(prim_run), .sec_run(sec_run), .strap_val(strap_val), .strap_drv(strap_drv),
    .bank_a_outputs(bank_a_outputs), .primary_clock_input(primary_clock_input),
    .secondary_clock_input(secondary_clock_input), .tunable_crystal_osc(tunable_crystal_osc),
    .ratio_select(ratio_select), .ratio_float(ratio_float), .feedback_input(feedback_input));
  ref_select_holdover_monitor u_dut (.clk_sys(clk_sys), .rst(rst), .primary_clock_input(primary_clock_input),
    .secondary_clock_input(secondary_clock_input), .input_chooser(input_chooser), .ratio_select(ratio_select),
    .ratio_float(ratio_float), .tunable_crystal_osc(tunable_crystal_osc), .feedback_input(feedback_input),
    .bank_a_outputs(bank_a_outputs), .bank_b_outputs(bank_b_outputs), .ref_valid(ref_valid),
    .bypass_active(bypass_active), .tune_code(tune_code));
  // Verdict and end of run
  task automatic tally_and_finish;
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Bounded wait for the flag level; running out is a mismatch
  task automatic wait_valid(input logic lvl, input int lim, output int c);
    c = 0;
    while (ref_valid !== lvl) begin
      if (c >= lim) begin
        bad_count++;
        $display("BAD %0t flag wait ran out", $time);
        tally_and_finish();
      end
      @(posedge clk_sys);
      #2;
      c++;
    end
  endtask
  // Rising edges seen on the output over a span of cycles
  task automatic count_rises(input int cyc, output int c);
    logic p;
    c = 0;
    p = bank_a_outputs[0];
    repeat (cyc) begin
      @(posedge clk_sys);
      #2;
      if (bank_a_outputs[0] === 1'b1 && p === 1'b0) c++;
      p = bank_a_outputs[0];
    end
  endtask
  // Bypass flag model: one register behind the effective strap code,
  // checked once the edge has settled
  always @(posedge clk_sys) begin
    byp_seen = ((strap_val | ~strap_drv) == 2'h0);
    #3;
    if (!rst) `CHK(bypass_active, byp_seen)
  end
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    input_chooser = 1'b1;
    prim_run = 1'b1;
    sec_run = 1'b1;
    strap_val = 2'h2;
    strap_drv = 2'h3;
    ref_half = 4;
    xtal_half = 8;
    bad_count = 0;
    cmp_count = 0;
    seed = 32'h077e443f;
    repeat (12) @(posedge clk_sys);
    #2;
    `CHK({bank_a_outputs, bank_b_outputs, ref_valid, tune_code}, {4'h0, 1'b0, 8'h80})
    rst = 1'b0;
    // Let two edges pass before any input moves
    repeat (2) @(posedge clk_sys);
    #2;
    // Reference period 8 cycles; crystal scaled per ratio code
    for (m = 1; m <= 3; m++) begin
      xtal_half = (m == 1) ? 2 : (m == 2) ? 8 : 24;
      per = 2 * xtal_half;
      prim_run = 1'b0;
      sec_run = 1'b0;
      strap_val = 2'(m);
      strap_drv = (m == 3) ? 2'h0 : 2'h3; // Code 11 from floating straps
      input_chooser = 1'($random(seed));
      wait_valid(1'b0, 40 * per, n);
      prim_run = 1'b1;
      sec_run = 1'b1;
      wait_valid(1'b1, 24 * per, n);
      `CHK(n > 12 * per, 1'b1)
      count_rises(160, n);
      `CHK(n >= 18 && n <= 22, 1'b1)
      if (m == 2) begin
        // Double rate lies outside capture range
        ref_half = 2;
        wait_valid(1'b0, 4 * per, n);
        ref_half = 4;
        wait_valid(1'b1, 24 * per, n);
        `CHK(n > 12 * per, 1'b1)
      end
      // Losing the other source leaves the flag alone
      if (input_chooser) sec_run = 1'b0;
      else prim_run = 1'b0;
      ok = 1'b1;
      repeat (4 * per) begin
        @(posedge clk_sys);
        #2;
        ok &= (ref_valid === 1'b1);
      end
      `CHK(ok, 1'b1)
      prim_run = 1'b0;
      sec_run = 1'b0;
      wait_valid(1'b0, ((m == 1) ? 3 : 2) * per + 4, n);
      t0 = tune_code;
      count_rises(160, n);
      `CHK(n > 0, 1'b1)
      `CHK(tune_code, t0)
    end
    // Both straps low: outputs follow the chosen reference
    strap_val = 2'h0;
    strap_drv = 2'h3;
    prim_run = 1'b1;
    sec_run = 1'b1;
    repeat (8) @(posedge clk_sys);
    #2;
    `CHK(bypass_active, 1'b1)
    count_rises(160, n);
    `CHK(n >= 19 && n <= 21, 1'b1)
    tally_and_finish();
  end
endmodule // ref_select_holdover_monitor_tb_top
`default_nettype wire
